// >>> include/power_save_pkg.sv
// Package with register map, field positions and power states
package power_save_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [4:0] BASIC_MODE_CONTROL_ADDR = 5'h00;
    localparam logic [4:0] PHY_SPECIAL_CONTROL_ADDR = 5'h11;
    localparam int BMC_POWER_DOWN_BIT = 11;
    localparam int PSC_SAVE_ENABLE_BIT = 14;
    localparam int PSC_SELECT_HI = 13;
    localparam int PSC_SELECT_LO = 12;
    localparam int PSC_IRQ_OE_BIT = 0;
    localparam logic [15:0] BASIC_MODE_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] PHY_SPECIAL_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] BASIC_MODE_CONTROL_MASK = 16'h0800;
    localparam logic [15:0] PHY_SPECIAL_CONTROL_MASK = 16'h7001;

    // ************************************************************
    // Power-save selections and states
    // ************************************************************
    localparam logic [1:0] SELECT_NONE = 2'h0;
    localparam logic [1:0] SELECT_IEEE_DOWN = 2'h1;
    localparam logic [1:0] SELECT_ACTIVE_SAVE = 2'h2;
    localparam logic [1:0] SELECT_PASSIVE_SAVE = 2'h3;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'h0,
        ST_IEEE_DOWN = 2'h1,
        ST_ACTIVE_SAVE = 2'h3,
        ST_PASSIVE_SAVE = 2'h2
    } power_state_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_t;

endpackage

// >>> core/phy_power_save_control.sv
// Power-save mode control reached over the management serial port
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// R1 - Pin low or control bit forces IEEE down
// R2 - Management registers stay accessible while down
// R3 - Bit 14 gates register-selected power-save modes
// R4 - Select 01 enters IEEE power down
// R5 - Select 10 enters active energy saving
// R6 - Select 11 enters passive energy saving
// R7 - Cleared select resumes state held before down
// R8 - Pin is power-down input until bit 0 set
// R9 - Enable with select 00 stays normal unless a pre-down state is held to resume
module phy_power_save_control import power_save_pkg::*; (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire mgmt_req_t mgmt_req_i,
    input wire logic irq_event_i,
    input wire logic irq_or_powerdown_pin_i,
    output logic irq_or_powerdown_pin_o,
    output logic irq_or_powerdown_pin_oe_n_o,
    output logic [15:0] mgmt_rdata_o,
    output logic mgmt_rvalid_o,
    output logic [1:0] power_state_o,
    output logic [1:0] resume_state_o,
    output logic functions_on_o
);

    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    logic pin_meta_reg, pin_sync_reg;
    logic pin_meta_next, pin_sync_next;

    always_comb begin
        pin_meta_next = pin_meta_reg;
        pin_sync_next = pin_sync_reg;
        if (enable_i) begin
            pin_meta_next = irq_or_powerdown_pin_i;
            pin_sync_next = pin_meta_reg;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
        end else begin
            pin_meta_reg <= pin_meta_next;
            pin_sync_reg <= pin_sync_next;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [15:0] bmc_reg, bmc_next;
    logic [15:0] psc_reg, psc_next;
    logic [15:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;

    // Registers never depend on the power state, so access works in every power state while enable_i is high
    always_comb begin
        bmc_next = bmc_reg;
        psc_next = psc_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        if (enable_i) begin
            if (mgmt_req_i.write) begin // R2
                if (mgmt_req_i.addr == BASIC_MODE_CONTROL_ADDR) begin
                    bmc_next = mgmt_req_i.wdata & BASIC_MODE_CONTROL_MASK;
                end
                if (mgmt_req_i.addr == PHY_SPECIAL_CONTROL_ADDR) begin
                    psc_next = mgmt_req_i.wdata & PHY_SPECIAL_CONTROL_MASK;
                end
            end
            if (mgmt_req_i.read) begin // R2
                rvalid_next = 1'b1;
                case (mgmt_req_i.addr)
                    BASIC_MODE_CONTROL_ADDR: rdata_next = bmc_reg;
                    PHY_SPECIAL_CONTROL_ADDR: rdata_next = psc_reg;
                    default: rdata_next = 16'h0000;
                endcase
            end
        end else begin
            rvalid_next = rvalid_reg;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            bmc_reg <= BASIC_MODE_CONTROL_RESET;
            psc_reg <= PHY_SPECIAL_CONTROL_RESET;
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            bmc_reg <= bmc_next;
            psc_reg <= psc_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ************************************************************
    // Power state machine
    // ************************************************************
    logic irq_mode;
    logic pin_down;
    logic save_on;
    logic [1:0] select;
    power_state_t state_reg, state_next;
    power_state_t resume_reg, resume_next;
    power_state_t target;
    logic pin_out_reg, pin_out_next;
    logic oe_n_reg, oe_n_next;
    logic on_reg, on_next;

    assign irq_mode = psc_reg[PSC_IRQ_OE_BIT];
    // The pin only powers down while it is an input
    assign pin_down = !irq_mode && !pin_sync_reg; // R8
    assign save_on = psc_reg[PSC_SAVE_ENABLE_BIT]; // R3
    assign select = psc_reg[PSC_SELECT_HI:PSC_SELECT_LO];

    always_comb begin
        target = ST_NORMAL;
        if (pin_down || bmc_reg[BMC_POWER_DOWN_BIT]) begin
            target = ST_IEEE_DOWN; // R1
        end else if (save_on) begin
            case (select)
                SELECT_IEEE_DOWN: target = ST_IEEE_DOWN; // R4
                SELECT_ACTIVE_SAVE: target = ST_ACTIVE_SAVE; // R5
                SELECT_PASSIVE_SAVE: target = ST_PASSIVE_SAVE; // R6
                default: target = ST_NORMAL; // R9
            endcase
        end
    end

    always_comb begin
        state_next = state_reg;
        resume_next = resume_reg;
        on_next = on_reg;
        pin_out_next = pin_out_reg;
        oe_n_next = oe_n_reg;
        if (enable_i) begin
            // Only the pre-down state is kept; one level of history
            if (target == ST_IEEE_DOWN) begin
                state_next = ST_IEEE_DOWN;
                if (state_reg != ST_IEEE_DOWN) begin
                    resume_next = state_reg; // R7
                end
            end else if (target != ST_NORMAL) begin
                state_next = target;
                resume_next = ST_NORMAL;
            end else if (save_on && (state_reg == ST_IEEE_DOWN
                         || state_reg == resume_reg)) begin
                // Resumed state is held until the gate or select moves
                state_next = resume_reg; // R7
            end else begin
                state_next = ST_NORMAL; // R9
                resume_next = ST_NORMAL;
            end
            on_next = (state_next != ST_IEEE_DOWN); // R2
            oe_n_next = !irq_mode; // R8
            pin_out_next = !irq_event_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= ST_NORMAL;
            resume_reg <= ST_NORMAL;
            on_reg <= 1'b1;
            pin_out_reg <= 1'b1;
            oe_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            resume_reg <= resume_next;
            on_reg <= on_next;
            pin_out_reg <= pin_out_next;
            oe_n_reg <= oe_n_next;
        end
    end

    assign power_state_o = state_reg;
    assign resume_state_o = resume_reg;
    assign functions_on_o = on_reg;
    assign mgmt_rdata_o = rdata_reg;
    assign mgmt_rvalid_o = rvalid_reg;
    assign irq_or_powerdown_pin_o = pin_out_reg;
    assign irq_or_powerdown_pin_oe_n_o = oe_n_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    a_bit_forces_down: assert property ( // R1
        @(posedge clock_i) disable iff (reset_i)
        enable_i && bmc_reg[BMC_POWER_DOWN_BIT] |=> state_reg == ST_IEEE_DOWN)
        else $error("control bit did not force power down");
    a_pin_forces_down: assert property ( // R1
        @(posedge clock_i) disable iff (reset_i)
        enable_i && pin_down |=> state_reg == ST_IEEE_DOWN)
        else $error("pin did not force power down");
    a_read_while_down: assert property ( // R2
        @(posedge clock_i) disable iff (reset_i)
        enable_i && mgmt_req_i.read && state_reg == ST_IEEE_DOWN
        |=> mgmt_rvalid_o)
        else $error("read lost during power down");
    a_gate_disabled: assert property ( // R3
        @(posedge clock_i) disable iff (reset_i)
        enable_i && !save_on && !pin_down && !bmc_reg[BMC_POWER_DOWN_BIT]
        |=> state_reg == ST_NORMAL)
        else $error("power save active while disabled");
    a_select_down: assert property ( // R4
        @(posedge clock_i) disable iff (reset_i)
        enable_i && save_on && select == SELECT_IEEE_DOWN
        |=> state_reg == ST_IEEE_DOWN)
        else $error("select 01 missed power down");
    a_select_active: assert property ( // R5
        @(posedge clock_i) disable iff (reset_i)
        enable_i && save_on && select == SELECT_ACTIVE_SAVE && !pin_down
        && !bmc_reg[BMC_POWER_DOWN_BIT] |=> state_reg == ST_ACTIVE_SAVE)
        else $error("select 10 missed active saving");
    a_select_passive: assert property ( // R6
        @(posedge clock_i) disable iff (reset_i)
        enable_i && save_on && select == SELECT_PASSIVE_SAVE && !pin_down
        && !bmc_reg[BMC_POWER_DOWN_BIT] |=> state_reg == ST_PASSIVE_SAVE)
        else $error("select 11 missed passive saving");
    a_resume_saved: assert property ( // R7
        @(posedge clock_i) disable iff (reset_i)
        enable_i && state_reg != ST_IEEE_DOWN && target == ST_IEEE_DOWN
        |=> resume_reg == $past(state_reg))
        else $error("pre-down state not kept");
    a_resume_return: assert property ( // R7
        @(posedge clock_i) disable iff (reset_i)
        enable_i && state_reg == ST_IEEE_DOWN && target == ST_NORMAL && save_on
        |=> state_reg == $past(resume_reg))
        else $error("cleared select did not resume");
    a_resume_holds: assert property ( // R7
        @(posedge clock_i) disable iff (reset_i)
        enable_i && state_reg != ST_NORMAL && state_reg == resume_reg
        && target == ST_NORMAL && save_on |=> $stable(state_reg))
        else $error("resumed state not held");
    a_pin_input_mode: assert property ( // R8
        @(posedge clock_i) disable iff (reset_i)
        enable_i && !irq_mode |=> irq_or_powerdown_pin_oe_n_o)
        else $error("pin driven while in input mode");
    a_select_zero: assert property ( // R9
        @(posedge clock_i) disable iff (reset_i)
        enable_i && target == ST_NORMAL && resume_reg == ST_NORMAL
        |=> state_reg == ST_NORMAL)
        else $error("select 00 left normal");

endmodule

`default_nettype wire

// >>> sim/station_model.sv
// Station manager model: issues management requests, resolves shared pin
`timescale 1ns/10ps
`default_nettype none
module station_model import power_save_pkg::*; (
    input wire mgmt_req_t cmd_i,
    input wire logic hold_low_i,
    input wire logic dev_pin_i,
    input wire logic dev_oe_n_i,
    output mgmt_req_t req_o,
    output logic pin_o
);
    // ********************************************
    // Request path and pin resolution
    // ********************************************
    // Requests pass straight through; the bench sets their timing
    assign req_o = cmd_i;
    // Weak pull-up unless someone pulls low; a driving device wins
    assign pin_o = dev_oe_n_i ? !hold_low_i : dev_pin_i;
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the power-save control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import power_save_pkg::*;
    // ********************************************
    // Stimulus, checks and run control
    // ********************************************
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic irq_event = 1'b0;
    logic hold_low = 1'b0;
    logic enable = 1'b1;
    mgmt_req_t cmd = '0;
    mgmt_req_t req;
    logic pin, pin_o, oe_n, rvalid, fon;
    logic [15:0] rdata, v, got;
    logic [1:0] st, rs;
    int num_errors = 0;
    int compares = 0;
    int seed = 67014;
    logic [15:0] tbl [4] = '{16'h4000, 16'h3000, 16'h6000, 16'h7000};
    always #5 clock_i = ~clock_i;
    station_model sm (.cmd_i(cmd), .hold_low_i(hold_low), .dev_pin_i(pin_o),
        .dev_oe_n_i(oe_n), .req_o(req), .pin_o(pin));
    phy_power_save_control uut (.clock_i(clock_i), .reset_i(reset_i),
        .enable_i(enable), .mgmt_req_i(req), .irq_event_i(irq_event),
        .irq_or_powerdown_pin_i(pin), .irq_or_powerdown_pin_o(pin_o),
        .irq_or_powerdown_pin_oe_n_o(oe_n), .mgmt_rdata_o(rdata),
        .mgmt_rvalid_o(rvalid), .power_state_o(st), .resume_state_o(rs),
        .functions_on_o(fon));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock_i) cmd <= '{1'b1, 1'b0, a, d};
        @(posedge clock_i) cmd <= '0;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clock_i) cmd <= '{1'b0, 1'b1, a, 16'h0};
        @(posedge clock_i) cmd <= '0;
        #1;
        check(16'(rvalid), 16'h1);
        d = rdata;
        @(posedge clock_i);
        #1;
        check(16'(rvalid), 16'h0);
    endtask
    // Pin passes a two-stage synchroniser before the state register
    task automatic wait_pin;
        repeat (5) @(posedge clock_i);
        #1;
    endtask
    function automatic logic [1:0] exp_state(input logic [15:0] p);
        if (!p[14]) return 2'h0;
        case (p[13:12])
            2'h1: return 2'h1;
            2'h2: return 2'h3;
            2'h3: return 2'h2;
            default: return 2'h0;
        endcase
    endfunction
    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clock_i);
        reset_i <= 1'b0;
        #1;
        check(16'(oe_n), 16'h1);
        check(16'(st), 16'h0);
        hold_low <= 1'b1;
        wait_pin();
        check(16'(st), 16'h1);
        check(16'(fon), 16'h0);
        rd(PHY_SPECIAL_CONTROL_ADDR, v);
        check(v, 16'h0);
        hold_low <= 1'b0;
        wait_pin();
        check(16'(st), 16'h0);
        wr(BASIC_MODE_CONTROL_ADDR, 16'hffff);
        check(16'(st), 16'h1);
        rd(BASIC_MODE_CONTROL_ADDR, v);
        check(v, 16'h0800);
        wr(BASIC_MODE_CONTROL_ADDR, 16'h0);
        // Directed corners first, then random; select 01 kept out here
        // because leaving it depends on the remembered state
        for (int i = 0; i < 24; i++) begin
            v = (i < 4) ? tbl[i] : 16'($random(seed));
            if (v[13:12] == 2'h1) v[13] = 1'b1;
            wr(PHY_SPECIAL_CONTROL_ADDR, v);
            check(16'(st), 16'(exp_state(v)));
            check(16'(fon), 16'h1);
            rd(PHY_SPECIAL_CONTROL_ADDR, got);
            check(got, v & PHY_SPECIAL_CONTROL_MASK);
        end
        wr(PHY_SPECIAL_CONTROL_ADDR, 16'h6000);
        wr(PHY_SPECIAL_CONTROL_ADDR, 16'h5000);
        check(16'(st), 16'h1);
        check(16'(rs), 16'h3);
        wr(PHY_SPECIAL_CONTROL_ADDR, 16'h4000);
        check(16'(st), 16'h3);
        check(16'(fon), 16'h1);
        wr(PHY_SPECIAL_CONTROL_ADDR, 16'h0001);
        check(16'(st), 16'h0);
        check(16'(oe_n), 16'h0);
        @(posedge clock_i);
        irq_event <= 1'b1;
        hold_low <= 1'b1;
        wait_pin();
        check(16'(pin), 16'h0);
        check(16'(st), 16'h0);
        @(posedge clock_i);
        irq_event <= 1'b0;
        hold_low <= 1'b0;
        rd(5'h05, v);
        check(v, 16'h0);
        // Clock enable low freezes everything, a write included
        @(posedge clock_i) enable <= 1'b0;
        wr(BASIC_MODE_CONTROL_ADDR, 16'h0800);
        check(16'(st), 16'h0);
        @(posedge clock_i) enable <= 1'b1;
        rd(BASIC_MODE_CONTROL_ADDR, v);
        check(v, 16'h0);
        // Reset in mid-run while powered down
        wr(BASIC_MODE_CONTROL_ADDR, 16'h0800);
        check(16'(st), 16'h1);
        @(posedge clock_i) reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        #1;
        check(16'(st), 16'h0);
        check(16'(fon), 16'h1);
        rd(BASIC_MODE_CONTROL_ADDR, v);
        check(v, 16'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
